// ==== ttx_pkg.sv ====
package ttx_pkg;

	// Host port widths and the number of stages in a pin synchroniser.
	localparam int HOST_DATA_W = 4;
	localparam int SYNC_STAGES = 2;

	// Values of the register pick input.
	localparam logic PICK_DATA = 1'h0;
	localparam logic PICK_CTRL = 1'h1;

	// Control nibble, written with the pick input high.
	localparam int CTRL_IRQ_MODE_BIT = 0;
	localparam logic [3:0] CTRL_RESET = 4'h1;

	// Status nibble, read with the pick input high.
	localparam int STAT_RX_BIT = 0;
	localparam int STAT_TX_BIT = 1;
	localparam int STAT_DSTEER_BIT = 2;

	// Oscillator rate and the latch settle delay counted in oscillator cycles.
	localparam int OSC_HZ = 3579545;
	localparam int SETTLE_OSC_CYCLES = 4;

	// Host pins as they arrive at the device.
	typedef struct packed {
		logic csN;
		logic rdN;
		logic wrN;
		logic pick;
		logic [HOST_DATA_W-1:0] data;
	} ttx_host_pins_t;

	localparam int HOST_PINS_W = $bits(ttx_host_pins_t);

	// Idle levels of the host pins, used as the synchroniser reset value.
	localparam ttx_host_pins_t HOST_PINS_IDLE = '{csN: 1'h1, rdN: 1'h1, wrN: 1'h1, pick: 1'h0, data: 4'h0};

	typedef enum logic [1:0] {
		STEER_FREE,
		STEER_SETTLE,
		STEER_HELD
	} ttx_steer_t;

endpackage : ttx_pkg

// ==== ttx_sync.sv ====
`timescale 1ns/1ns
module ttx_sync import ttx_pkg::*; #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic resetN,
	// Asynchronous input and its synchronised copy.
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_syncOut;

	initial begin
		if (WIDTH < 1) begin
			$error("ttx_sync needs a width of at least one");
		end
	end

	always_comb begin
		next_stage1 = asyncIn;
		next_syncOut = stage1;
	end

	always_ff @(posedge clock or negedge resetN) begin
		if (!resetN) begin
			stage1 <= RESET_VALUE;
			syncOut <= RESET_VALUE;
		end else begin
			stage1 <= next_stage1;
			syncOut <= next_syncOut;
		end
	end

endmodule : ttx_sync

// ==== ttx_host_port.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - The data lines float whenever the select is high or the read strobe is high.
// - The register pick input chooses which register a read or write strobe reaches.
// - In interrupt mode the request pin pulls low after a tone burst is sent or a tone pair is received.
// - In call progress mode the request pin follows the squared-up in-band signal.
// - Early pair detect goes high on a valid tone pair and low on any loss of it.
// - Steer above threshold registers the detected pair and updates the output latch.
// - Steer below threshold frees the device to take a new pair.
// - The guard output resets the steering network and depends on early detect and the steer level.
// - All internal timing comes from the oscillator input at its nominal rate; here only the settle delay counts oscillator edges, the rest runs on clock.
// - Registering a pair latches its four-bit code into the receive data register.
// - A read of the receive data register drives the code onto the data lines.
// - In interrupt mode the request pin stays low while the delayed steering flag is set.
module ttx_host_port import ttx_pkg::*; #(
	parameter int SETTLE_CYCLES = SETTLE_OSC_CYCLES
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// Oscillator input.
	input wire logic osc_in,
	// Host port pins.
	input wire ttx_host_pins_t hostPins,
	output logic [HOST_DATA_W-1:0] hostDataOut,
	output logic hostDataOeN,
	// Request or tone activity open-drain pin.
	output logic requestOrToneActivityOut,
	output logic requestOrToneActivityOeN,
	// Steer pin and early detect output.
	input wire logic steerIn,
	output logic guardTimeDrive,
	output logic guardOeN,
	output logic earlyPairDetect,
	// Detector and transmitter side.
	input wire logic pairValid,
	input wire logic [HOST_DATA_W-1:0] pairCode,
	input wire logic toneBurstSent,
	input wire logic callProgressIn
);

	localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

	logic [1:0] resetSync;
	logic resetN;
	ttx_host_pins_t hostS;
	logic steerS;
	logic oscS;
	logic cpS;
	logic wrPrev;
	logic rdPrev;
	logic oscPrev;
	logic rdActive;
	logic wrRise;
	logic statusReadEnd;
	logic oscTick;
	logic [HOST_DATA_W-1:0] ctrl;
	logic [HOST_DATA_W-1:0] rxData;
	logic [HOST_DATA_W-1:0] status;
	logic rxFlag;
	logic txFlag;
	logic irqMode;
	ttx_steer_t state;
	logic [CNT_W-1:0] settleCount;
	ttx_steer_t next_state;
	logic [CNT_W-1:0] next_settleCount;
	logic [HOST_DATA_W-1:0] next_ctrl;
	logic [HOST_DATA_W-1:0] next_rxData;
	logic [HOST_DATA_W-1:0] next_hostDataOut;
	logic next_rxFlag;
	logic next_txFlag;
	logic next_earlyPairDetect;

	initial begin
		if (SETTLE_CYCLES < 1) begin
			$error("SETTLE_CYCLES must be at least one");
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			resetSync <= 2'h0;
		end else begin
			resetSync <= {resetSync[0], 1'h1};
		end
	end
	assign resetN = resetSync[1];

	ttx_sync #(.WIDTH(HOST_PINS_W), .RESET_VALUE(HOST_PINS_IDLE)) hostSync (
		.clock(clock),
		.resetN(resetN),
		.asyncIn(hostPins),
		.syncOut(hostS)
	);

	ttx_sync #(.WIDTH(3), .RESET_VALUE(3'h1)) lineSync (
		.clock(clock),
		.resetN(resetN),
		.asyncIn({steerIn, osc_in, callProgressIn}),
		.syncOut({steerS, oscS, cpS})
	);

	assign oscTick = oscS && !oscPrev;
	assign rdActive = !hostS.csN && !hostS.rdN;
	assign statusReadEnd = rdPrev && !(rdActive && hostS.pick == PICK_CTRL);
	assign wrRise = hostS.wrN && !wrPrev && !hostS.csN;
	assign irqMode = ctrl[CTRL_IRQ_MODE_BIT];

	always_comb begin
		status = '0;
		status[STAT_RX_BIT] = rxFlag;
		status[STAT_TX_BIT] = txFlag;
		status[STAT_DSTEER_BIT] = (state == STEER_HELD);
	end

	always_comb begin
		next_state = state;
		next_settleCount = settleCount;
		next_rxData = rxData;
		case (state)
			STEER_FREE: begin
				if (steerS) begin
					next_rxData = pairCode;
					next_settleCount = '0;
					next_state = STEER_SETTLE;
				end
			end
			STEER_SETTLE: begin
				if (!steerS) begin
					next_state = STEER_FREE;
				end else if (oscTick) begin
					if (settleCount == CNT_W'(SETTLE_CYCLES - 1)) begin
						next_state = STEER_HELD;
					end else begin
						next_settleCount = settleCount + CNT_W'(1);
					end
				end
			end
			default: begin
				if (!steerS) begin
					next_state = STEER_FREE;
				end
			end
		endcase
	end

	// sticky event flags, set wins over clear.
	always_comb begin
		next_rxFlag = rxFlag;
		next_txFlag = txFlag;
		// Flags clear when a status read ends, so that the read returns them first.
		if (statusReadEnd) begin
			next_rxFlag = 1'h0;
			next_txFlag = 1'h0;
		end
		if (state == STEER_SETTLE && next_state == STEER_HELD) begin
			next_rxFlag = 1'h1;
		end
		if (toneBurstSent) begin
			next_txFlag = 1'h1;
		end
	end

	always_comb begin
		next_ctrl = ctrl;
		if (wrRise && hostS.pick == PICK_CTRL) begin
			next_ctrl = hostS.data;
		end
		next_hostDataOut = (hostS.pick == PICK_DATA) ? rxData : status;
		next_earlyPairDetect = pairValid;
	end

	always_ff @(posedge clock or negedge resetN) begin
		if (!resetN) begin
			state <= STEER_FREE;
			settleCount <= '0;
			rxData <= '0;
			rxFlag <= 1'h0;
			txFlag <= 1'h0;
			ctrl <= CTRL_RESET;
			hostDataOut <= '0;
			earlyPairDetect <= 1'h0;
			wrPrev <= 1'h1;
			rdPrev <= 1'h0;
			oscPrev <= 1'h1;
		end else begin
			state <= next_state;
			settleCount <= next_settleCount;
			rxData <= next_rxData;
			rxFlag <= next_rxFlag;
			txFlag <= next_txFlag;
			ctrl <= next_ctrl;
			hostDataOut <= next_hostDataOut;
			earlyPairDetect <= next_earlyPairDetect;
			wrPrev <= hostS.wrN;
			rdPrev <= rdActive && hostS.pick == PICK_CTRL;
			oscPrev <= oscS;
		end
	end

	assign hostDataOeN = !rdActive;
	// guard drive while steer is high.
	assign guardOeN = !steerS;
	assign guardTimeDrive = earlyPairDetect;
	assign requestOrToneActivityOut = 1'h0;
	// in interrupt mode, held low while delayed steering is set.
	assign requestOrToneActivityOeN = irqMode ? !(rxFlag || txFlag || state == STEER_HELD) : cpS;

	sequence sRegister;
		state == STEER_FREE && steerS ##1 state == STEER_SETTLE;
	endsequence

	sequence sSettleEnd;
		state == STEER_SETTLE && steerS && oscTick && settleCount == CNT_W'(SETTLE_CYCLES - 1);
	endsequence

	a_data_float: assert property (@(posedge clock) disable iff (!resetN) (hostS.csN || hostS.rdN) |-> hostDataOeN)
		else $error("data lines driven while not read");
	a_read_data: assert property (@(posedge clock) disable iff (!resetN)
		rdActive && hostS.pick == PICK_DATA |=> hostDataOut == $past(rxData))
		else $error("read data not the receive code");
	a_write_ctrl: assert property (@(posedge clock) disable iff (!resetN)
		wrRise && hostS.pick == PICK_CTRL |=> ctrl == $past(hostS.data))
		else $error("write not captured");
	a_code_latch: assert property (@(posedge clock) disable iff (!resetN)
		state == STEER_FREE && steerS |=> rxData == $past(pairCode))
		else $error("code not latched on registration");
	a_steer_register: assert property (@(posedge clock) disable iff (!resetN)
		sRegister ##0 steerS [*2] |-> state != STEER_FREE)
		else $error("registration lost while steer high");
	a_steer_free: assert property (@(posedge clock) disable iff (!resetN) !steerS |=> state == STEER_FREE)
		else $error("steer low did not free the receiver");
	a_settle_done: assert property (@(posedge clock) disable iff (!resetN)
		sSettleEnd |=> state == STEER_HELD && rxFlag)
		else $error("delayed steering not raised after settle");
	a_early_drop: assert property (@(posedge clock) disable iff (!resetN)
		pairValid ##1 !pairValid |=> !earlyPairDetect)
		else $error("early detect did not drop");
	a_guard_drive: assert property (@(posedge clock) disable iff (!resetN)
		steerS |-> !guardOeN && guardTimeDrive == earlyPairDetect)
		else $error("guard output wrong");
	a_irq_request: assert property (@(posedge clock) disable iff (!resetN)
		irqMode && (state == STEER_HELD || txFlag) |-> !requestOrToneActivityOeN)
		else $error("request not pulled low");
	a_tx_request: assert property (@(posedge clock) disable iff (!resetN)
		irqMode && toneBurstSent |=> !requestOrToneActivityOeN)
		else $error("transmit event did not request");
	a_cp_follow: assert property (@(posedge clock) disable iff (!resetN)
		!irqMode |-> requestOrToneActivityOeN == cpS)
		else $error("call progress output does not follow input");

endmodule : ttx_host_port

// ==== ttx_host_model.sv ====
`timescale 1ns/1ns
module ttx_host_model import ttx_pkg::*; (
	// Clock.
	input wire logic clock,
	// Device data lines.
	input wire logic [HOST_DATA_W-1:0] hostDataOut,
	input wire logic hostDataOeN,
	// Host pins towards the device.
	output ttx_host_pins_t hostPins
);
	initial begin
		hostPins = HOST_PINS_IDLE;
	end
	// One host access; a read with sel low must find the data lines floating.
	task automatic access(input logic sel, input logic rd, input logic pick, input logic [HOST_DATA_W-1:0] wdata,
		output logic [HOST_DATA_W-1:0] rdata, output logic driven);
		@(negedge clock);
		hostPins.csN = ~sel;
		hostPins.pick = pick;
		hostPins.data = wdata;
		hostPins.rdN = ~rd;
		hostPins.wrN = rd;
		repeat (5) @(negedge clock);
		rdata = hostDataOut;
		driven = ~hostDataOeN;
		hostPins.rdN = 1'h1;
		hostPins.wrN = 1'h1;
		// data, pick and select held three cycles after the read or write strobe rises.
		repeat (3) @(negedge clock);
		hostPins.csN = 1'h1;
		hostPins.data = ~wdata;
		repeat (4) @(negedge clock);
	endtask : access
endmodule : ttx_host_model

// ==== tone_transceiver_host_and_steering_tb_top.sv ====
`timescale 1ns/1ns
module tone_transceiver_host_and_steering_tb_top import ttx_pkg::*; ();
	logic clock, rst_b, osc_in, steerIn, pairValid, toneBurstSent, callProgressIn;
	logic hostDataOeN, reqOut, reqOeN, guardTimeDrive, guardOeN, earlyPairDetect, driven;
	logic [3:0] hostDataOut, pairCode, rdata;
	ttx_host_pins_t hostPins;
	int failures, check_count, cycles;

	ttx_host_port #(.SETTLE_CYCLES(1)) ttx_host_port_inst (.clock(clock), .rst_b(rst_b), .osc_in(osc_in),
		.hostPins(hostPins), .hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN),
		.requestOrToneActivityOut(reqOut), .requestOrToneActivityOeN(reqOeN), .steerIn(steerIn),
		.guardTimeDrive(guardTimeDrive), .guardOeN(guardOeN), .earlyPairDetect(earlyPairDetect),
		.pairValid(pairValid), .pairCode(pairCode), .toneBurstSent(toneBurstSent), .callProgressIn(callProgressIn));
	ttx_host_model ttx_host_model_inst (.clock(clock), .hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN),
		.hostPins(hostPins));

	always #5 clock = ~clock;
	always #140 osc_in = ~osc_in;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		if (failures == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude

	task automatic rd(input logic sel, input logic pick);
		ttx_host_model_inst.access(sel, 1'h1, pick, 4'h0, rdata, driven);
	endtask : rd

	task automatic wr(input logic [3:0] d);
		ttx_host_model_inst.access(1'h1, 1'h0, PICK_CTRL, d, rdata, driven);
	endtask : wr

	task automatic t_reset();
		check({hostDataOeN, reqOeN, guardOeN, earlyPairDetect}, 4'hE);
		rd(1'h0, PICK_DATA);
		check(driven, 1'h0);
		check(hostDataOeN, 1'h1);
	endtask : t_reset

	task automatic t_steer();
		pairCode = 4'hC;
		pairValid = 1'h1;
		@(negedge clock);
		check(earlyPairDetect, 1'h1);
		steerIn = 1'h1;
		repeat (4) @(negedge clock);
		check({guardOeN, guardTimeDrive}, 2'h1);
		pairCode = 4'h3;
		repeat (40) @(negedge clock);
		check(reqOeN, 1'h0);
		rd(1'h1, PICK_CTRL);
		check(rdata, 4'h5);
		rd(1'h1, PICK_DATA);
		check(rdata, 4'hC);
		check(driven, 1'h1);
		check(hostDataOeN, 1'h1);
		rd(1'h1, PICK_CTRL);
		check(rdata, 4'h4);
		check(reqOeN, 1'h0);
		pairValid = 1'h0;
		@(negedge clock);
		check({earlyPairDetect, guardTimeDrive}, 2'h0);
		steerIn = 1'h0;
		repeat (5) @(negedge clock);
		check({guardOeN, reqOeN}, 2'h3);
		steerIn = 1'h1;
		repeat (45) @(negedge clock);
		rd(1'h1, PICK_DATA);
		check(rdata, 4'h3);
		steerIn = 1'h0;
		repeat (5) @(negedge clock);
		rd(1'h1, PICK_CTRL);
		check(rdata, 4'h1);
	endtask : t_steer

	task automatic t_tx();
		check(reqOeN, 1'h1);
		toneBurstSent = 1'h1;
		@(negedge clock);
		toneBurstSent = 1'h0;
		repeat (3) @(negedge clock);
		check(reqOeN, 1'h0);
		rd(1'h1, PICK_CTRL);
		check(rdata, 4'h2);
		check(reqOeN, 1'h1);
	endtask : t_tx

	task automatic t_callprog();
		wr(4'h0);
		callProgressIn = 1'h0;
		repeat (4) @(negedge clock);
		check(reqOeN, 1'h0);
		callProgressIn = 1'h1;
		repeat (4) @(negedge clock);
		check(reqOeN, 1'h1);
		callProgressIn = 1'h0;
		repeat (4) @(negedge clock);
		check(reqOeN, 1'h0);
		wr(CTRL_RESET);
		check(reqOeN, 1'h1);
	endtask : t_callprog

	initial begin
		clock = 1'h0;
		osc_in = 1'h0;
		rst_b = 1'h0;
		steerIn = 1'h0;
		pairValid = 1'h0;
		pairCode = 4'h0;
		toneBurstSent = 1'h0;
		callProgressIn = 1'h1;
		repeat (10) @(negedge clock);
		rst_b = 1'h1;
		repeat (6) @(negedge clock);
		t_reset();
		t_steer();
		t_tx();
		t_callprog();
		conclude();
	end
endmodule : tone_transceiver_host_and_steering_tb_top
